// *** hdl/tcd_dma_control.v ***
// Local design decision: the AHB-Lite slave port.
`include "tcd_defines.vh"

module tcd_dma_control (
    clk,
    resetn,
    hsel,
    haddr,
    htrans,
    hwrite,
    hsize,
    hwdata,
    hready,
    hreadyout,
    hresp,
    hrdata,
    external_request_pin,
    serial_receive_request,
    serial_transmit_request,
    nmi_event,
    request_ack_pin,
    end_irq,
    bus_hold,
    bus_addr,
    bus_read,
    bus_write,
    bus_size
);
    input wire clk;
    input wire resetn;
    input wire hsel;
    input wire [31:0] haddr;
    input wire [1:0] htrans;
    input wire hwrite;
    input wire [2:0] hsize;
    input wire [31:0] hwdata;
    input wire hready;
    output wire hreadyout;
    output wire hresp;
    output reg [31:0] hrdata;
    input wire [1:0] external_request_pin; // Async pins
    input wire [1:0] serial_receive_request; // Per channel
    input wire [1:0] serial_transmit_request;
    input wire nmi_event; // One-cycle pulse
    output wire [1:0] request_ack_pin;
    output wire [1:0] end_irq;
    output wire bus_hold; // Controller owns the bus
    output wire [31:0] bus_addr;
    output wire bus_read;
    output wire bus_write;
    output wire [1:0] bus_size;

    // ************************************************
    // Engine states, one-hot
    // ************************************************
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_RD = 3'h2;
    localparam [2:0] ST_WR = 3'h4;
    // Select indices exceed the word index; only low 30 bits decode
    localparam [31:0] IX_RS0 = `TCD_IDX_RSEL0;
    localparam [31:0] IX_RS1 = `TCD_IDX_RSEL1;

    // ************************************************
    // Bus slave
    // ************************************************
    reg wr_pend_reg; // Write data phase pending
    reg [29:0] wr_idx_reg; // Word index of that write
    wire acc_go; // Valid address phase
    wire [29:0] a_idx; // Address phase word index
    reg [31:0] rd_mux; // Read value at address phase
    reg [3:0] op_reg; // Operation register bits 3:0
    reg nmi_armed_reg; // Flag read as one
    reg ae_armed_reg;
    wire [31:0] cc_all; // Both channel controls
    wire [3:0] rs_all;
    wire [47:0] cnt_all;
    wire [63:0] src_all;
    wire [63:0] dst_all;
    wire [1:0] can_go; // Channel may start
    wire [1:0] req_on; // Channel request present
    wire [1:0] te_set; // Normal end this cycle
    reg [2:0] st_reg;
    reg act_reg; // Active channel
    reg last_reg; // Last channel served
    reg [1:0] sub_reg; // Longword within 16-byte unit
    reg pick; // Arbitration winner
    wire ae_hit; // Misaligned start
    wire nmi_clr;
    wire ae_clr;

    assign hreadyout = 1'b1; // Zero wait states
    assign hresp = 1'b0; // Always OKAY
    assign acc_go = hsel & htrans[1] & hready;
    assign a_idx = haddr[31:2];

    // Read mux; unmapped words read as zero
    always @* begin
        rd_mux = 32'h0;
        case (a_idx)
            `TCD_IDX_OPER: rd_mux = {28'h0, op_reg};
            IX_RS0[29:0]: rd_mux = {30'h0, rs_all[1:0]};
            IX_RS1[29:0]: rd_mux = {30'h0, rs_all[3:2]};
            `TCD_IDX_CHC0: rd_mux = {16'h0, cc_all[15:0]};
            `TCD_IDX_CHC1: rd_mux = {16'h0, cc_all[31:16]};
            `TCD_IDX_CNT0: rd_mux = {8'h0, cnt_all[23:0]};
            `TCD_IDX_CNT1: rd_mux = {8'h0, cnt_all[47:24]};
            `TCD_IDX_SRC0: rd_mux = src_all[31:0];
            `TCD_IDX_SRC1: rd_mux = src_all[63:32];
            `TCD_IDX_DST0: rd_mux = dst_all[31:0];
            `TCD_IDX_DST1: rd_mux = dst_all[63:32];
            default: rd_mux = 32'h0;
        endcase
    end

    // Capture address phase; read data ready in data phase
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= 30'h0;
            hrdata <= 32'h0;
        end else begin
            wr_pend_reg <= acc_go & hwrite;
            if (acc_go) begin
                wr_idx_reg <= a_idx;
                if (!hwrite) begin
                    hrdata <= rd_mux;
                end
            end
        end
    end

    // ************************************************
    // Operation register
    // ************************************************
    wire op_wr;
    wire op_rd;
    assign op_wr = wr_pend_reg && (wr_idx_reg == `TCD_IDX_OPER);
    assign op_rd = acc_go && !hwrite && (a_idx == `TCD_IDX_OPER);
    // Only a zero after a read of one clears a flag
    assign nmi_clr = op_wr & nmi_armed_reg & ~hwdata[`TCD_OP_NMI];
    assign ae_clr = op_wr & ae_armed_reg & ~hwdata[`TCD_OP_AE];

    // Flags: hardware set wins over software clear
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            op_reg <= `TCD_OP_RESET;
            nmi_armed_reg <= 1'b0;
            ae_armed_reg <= 1'b0;
        end else begin
            if (op_wr) begin
                op_reg[`TCD_OP_PR] <= hwdata[`TCD_OP_PR];
                op_reg[`TCD_OP_DME] <= hwdata[`TCD_OP_DME];
                nmi_armed_reg <= 1'b0;
                ae_armed_reg <= 1'b0;
            end else if (op_rd) begin
                nmi_armed_reg <= op_reg[`TCD_OP_NMI];
                ae_armed_reg <= op_reg[`TCD_OP_AE];
            end
            // Writing one never sets a flag
            if (nmi_event) begin
                op_reg[`TCD_OP_NMI] <= 1'b1;
            end else if (nmi_clr) begin
                op_reg[`TCD_OP_NMI] <= 1'b0;
            end
            if (ae_hit) begin
                op_reg[`TCD_OP_AE] <= 1'b1;
            end else if (ae_clr) begin
                op_reg[`TCD_OP_AE] <= 1'b0;
            end
        end
    end

    // ************************************************
    // Per-channel registers and request detection
    // ************************************************
    wire unit_end; // Last cycle of a transfer unit
    wire sub_end; // Last cycle of each bus unit or longword
    wire halt;
    assign halt = ~op_reg[`TCD_OP_DME] | op_reg[`TCD_OP_NMI]
        | op_reg[`TCD_OP_AE];

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gen_ch
            reg [15:0] cc_reg;
            reg [1:0] rs_reg;
            reg [23:0] cnt_reg;
            reg [31:0] src_reg;
            reg [31:0] dst_reg;
            reg te_armed_reg;
            reg [2:0] sync_reg; // Pin synchroniser
            reg pin_reg; // Filtered pin level
            reg edge_reg; // Latched edge request
            reg pin_req;
            wire mine;
            wire go_now;
            wire cc_wr;
            wire cc_rd;
            wire [31:0] step;
            wire sel_src;
            wire sel_dst;

            assign mine = (act_reg == g);
            assign cc_wr = wr_pend_reg && (wr_idx_reg == `TCD_IDX_CHC0 + g);
            assign cc_rd = acc_go && !hwrite
                && (a_idx == `TCD_IDX_CHC0 + g);
            assign go_now = mine & (st_reg == ST_IDLE) & (|can_go)
                & (pick == g);
            // Step is the bus unit: 1, 2 or 4 bytes
            assign step = cc_reg[`TCD_CC_TS+1] ? 32'h4 :
                (cc_reg[`TCD_CC_TS] ? 32'h2 : 32'h1);
            // Single address: only the memory side moves
            assign sel_src = ~cc_reg[`TCD_CC_TA] | ~cc_reg[`TCD_CC_AM];
            assign sel_dst = ~cc_reg[`TCD_CC_TA] | cc_reg[`TCD_CC_AM];

            // Pin needs two agreeing late stages to count
            always @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    sync_reg <= 3'h0;
                    pin_reg <= 1'b0;
                end else begin
                    sync_reg <= {sync_reg[1:0], external_request_pin[g]};
                    if (sync_reg[1] == sync_reg[2]) begin
                        pin_reg <= sync_reg[2];
                    end
                end
            end

            // Source mux; reserved code gives no request
            always @* begin
                pin_req = 1'b0;
                case (rs_reg)
                    2'h0: begin
                        if (cc_reg[`TCD_CC_DS]) begin
                            pin_req = edge_reg;
                        end else begin
                            pin_req = ~(pin_reg ^ cc_reg[`TCD_CC_DL]);
                        end
                    end
                    2'h1: pin_req = serial_receive_request[g];
                    2'h2: pin_req = serial_transmit_request[g];
                    default: pin_req = 1'b0;
                endcase
            end
            // Auto request needs no source
            assign req_on[g] = cc_reg[`TCD_CC_AR] | pin_req;
            assign can_go[g] = req_on[g] & cc_reg[`TCD_CC_DE]
                & ~cc_reg[`TCD_CC_TE] & ~halt
                & (cnt_reg != 24'h0);
            assign te_set[g] = mine & unit_end & (cnt_reg == 24'h1);
            assign end_irq[g] = cc_reg[`TCD_CC_TE]
                & cc_reg[`TCD_CC_IE];
            // Acknowledge in the chosen cycle, chosen polarity
            assign request_ack_pin[g] = cc_reg[`TCD_CC_AL] ~^ (mine
                & (cc_reg[`TCD_CC_TA] | (cc_reg[`TCD_CC_AM] ?
                st_reg == ST_WR : st_reg == ST_RD))
                & (st_reg != ST_IDLE));

            // Edge latch, consumed when a unit starts or ends
            always @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    edge_reg <= 1'b0;
                end else if (!cc_reg[`TCD_CC_DS]) begin
                    // Level mode: no stale edge survives a mode change
                    edge_reg <= 1'b0;
                end else if ((sync_reg[1] == sync_reg[2])
                    && (sync_reg[2] != pin_reg)
                    && (sync_reg[2] == cc_reg[`TCD_CC_DL])) begin
                    edge_reg <= 1'b1;
                end else if (go_now || (mine && unit_end)) begin
                    edge_reg <= 1'b0;
                end
            end

            // Control, count and address registers
            always @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    cc_reg <= `TCD_CC_RESET;
                    rs_reg <= `TCD_RS_RESET;
                    cnt_reg <= 24'h0;
                    src_reg <= 32'h0;
                    dst_reg <= 32'h0;
                    te_armed_reg <= 1'b0;
                end else begin
                    if (cc_wr) begin
                        cc_reg <= {hwdata[15:2], cc_reg[1], hwdata[0]};
                        te_armed_reg <= 1'b0;
                    end else if (cc_rd) begin
                        te_armed_reg <= cc_reg[`TCD_CC_TE];
                    end
                    // Set wins; clear needs prior read of one
                    if (te_set[g]) begin
                        cc_reg[`TCD_CC_TE] <= 1'b1;
                    end else if (cc_wr && te_armed_reg
                        && !hwdata[`TCD_CC_TE]) begin
                        cc_reg[`TCD_CC_TE] <= 1'b0;
                    end
                    if (wr_pend_reg
                        && wr_idx_reg == IX_RS0[29:0] + g) begin
                        rs_reg <= hwdata[1:0];
                    end
                    // Software write wins over engine update
                    if (wr_pend_reg
                        && wr_idx_reg == `TCD_IDX_CNT0 + g) begin
                        cnt_reg <= hwdata[23:0];
                    end else if (mine && unit_end) begin
                        cnt_reg <= cnt_reg - 24'h1;
                    end
                    if (wr_pend_reg
                        && wr_idx_reg == `TCD_IDX_SRC0 + g) begin
                        src_reg <= hwdata;
                    end else if (mine && sub_end && sel_src) begin
                        if (cc_reg[`TCD_CC_SM+1:`TCD_CC_SM] == 2'h1) begin
                            src_reg <= src_reg + step;
                        end else if (cc_reg[`TCD_CC_SM+1:`TCD_CC_SM]
                            == 2'h2) begin
                            src_reg <= src_reg - step;
                        end
                    end
                    if (wr_pend_reg
                        && wr_idx_reg == `TCD_IDX_DST0 + g) begin
                        dst_reg <= hwdata;
                    end else if (mine && sub_end && sel_dst) begin
                        if (cc_reg[`TCD_CC_DM+1:`TCD_CC_DM] == 2'h1) begin
                            dst_reg <= dst_reg + step;
                        end else if (cc_reg[`TCD_CC_DM+1:`TCD_CC_DM]
                            == 2'h2) begin
                            dst_reg <= dst_reg - step;
                        end
                    end
                end
            end

            assign cc_all[g*16 +: 16] = cc_reg;
            assign rs_all[g*2 +: 2] = rs_reg;
            assign cnt_all[g*24 +: 24] = cnt_reg;
            assign src_all[g*32 +: 32] = src_reg;
            assign dst_all[g*32 +: 32] = dst_reg;
        end
    endgenerate

    // ************************************************
    // Arbitration and transfer engine
    // ************************************************
    wire [15:0] acc; // Active channel control
    wire [31:0] a_src;
    wire [31:0] a_dst;
    wire [15:0] p_cc; // Winner's control
    wire [31:0] p_src;
    wire [31:0] p_dst;
    wire [1:0] ts_p;
    wire mis;
    wire single;
    wire more;
    assign acc = act_reg ? cc_all[31:16] : cc_all[15:0];
    assign a_src = act_reg ? src_all[63:32] : src_all[31:0];
    assign a_dst = act_reg ? dst_all[63:32] : dst_all[31:0];
    assign p_cc = pick ? cc_all[31:16] : cc_all[15:0];
    assign p_src = pick ? src_all[63:32] : src_all[31:0];
    assign p_dst = pick ? dst_all[63:32] : dst_all[31:0];
    assign ts_p = p_cc[`TCD_CC_TS+1:`TCD_CC_TS];
    assign single = acc[`TCD_CC_TA];

    // Winner among ready channels
    always @* begin
        pick = 1'b0;
        if (can_go == 2'h2) begin
            pick = 1'b1;
        end else if (can_go == 2'h3) begin
            // Fixed: 0 first; rotating: not the last served
            pick = op_reg[`TCD_OP_PR] ? ~last_reg : 1'b0;
        end
    end

    // Misaligned start address is the controller's error
    assign mis = (ts_p == 2'h1) ? (p_src[0] | p_dst[0]) :
        ((ts_p[1]) ? (|p_src[1:0] | |p_dst[1:0]) : 1'b0);
    assign ae_hit = (st_reg == ST_IDLE) & (|can_go) & mis;

    // Longword count within a sixteen-byte unit
    assign sub_end = (st_reg == ST_WR);
    assign unit_end = sub_end & ((acc[`TCD_CC_TS+1:`TCD_CC_TS] != 2'h3)
        | (sub_reg == 2'h3));
    // Burst keeps going while allowed and requested
    assign more = acc[`TCD_CC_TB] & can_go[act_reg]
        & ~te_set[act_reg];

    // Engine: read then write, or one cycle in single mode
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= ST_IDLE;
            act_reg <= 1'b0;
            last_reg <= 1'b0; // Channel 1 ranks first in rotating mode
            sub_reg <= 2'h0;
        end else begin
            case (st_reg)
                ST_IDLE: begin
                    sub_reg <= 2'h0;
                    act_reg <= pick;
                    if ((|can_go) && !mis) begin
                        last_reg <= pick;
                        st_reg <= p_cc[`TCD_CC_TA] ? ST_WR : ST_RD;
                    end
                end
                ST_RD: begin
                    st_reg <= halt ? ST_IDLE : ST_WR;
                end
                ST_WR: begin
                    sub_reg <= sub_reg + 2'h1;
                    if (halt) begin
                        st_reg <= ST_IDLE;
                    end else if (!unit_end || more) begin
                        st_reg <= single ? ST_WR : ST_RD;
                    end else begin
                        // Cycle steal hands the bus back
                        st_reg <= ST_IDLE;
                    end
                end
                default: st_reg <= ST_IDLE;
            endcase
        end
    end

    // Bus cycle presented by the engine
    assign bus_hold = (st_reg != ST_IDLE);
    assign bus_read = (st_reg == ST_RD)
        | ((st_reg == ST_WR) & single & ~acc[`TCD_CC_AM]);
    assign bus_write = (st_reg == ST_WR) & ~bus_read;
    assign bus_addr = bus_read ? a_src : a_dst;
    assign bus_size = acc[`TCD_CC_TS+1] ? 2'h2 : acc[`TCD_CC_TS+1:`TCD_CC_TS];

endmodule // tcd_dma_control

// *** hdl/tcd_defines.vh ***
`ifndef TCD_DEFINES_VH
`define TCD_DEFINES_VH
// ****************************************************
// Register indices (byte address is four times these)
// ****************************************************
`define TCD_IDX_OPER 32'h0fffffb0
`define TCD_IDX_RSEL0 32'hfffffe71
`define TCD_IDX_RSEL1 32'hfffffe72
`define TCD_IDX_CHC0 32'h00000040
`define TCD_IDX_CHC1 32'h00000041
`define TCD_IDX_CNT0 32'h00000042
`define TCD_IDX_CNT1 32'h00000043
`define TCD_IDX_SRC0 32'h00000044
`define TCD_IDX_SRC1 32'h00000045
`define TCD_IDX_DST0 32'h00000046
`define TCD_IDX_DST1 32'h00000047
// ****************************************************
// Channel control fields
// ****************************************************
`define TCD_CC_DM 14
`define TCD_CC_SM 12
`define TCD_CC_TS 10
`define TCD_CC_AR 9
`define TCD_CC_AM 8
`define TCD_CC_AL 7
`define TCD_CC_DS 6
`define TCD_CC_DL 5
`define TCD_CC_TB 4
`define TCD_CC_TA 3
`define TCD_CC_IE 2
`define TCD_CC_TE 1
`define TCD_CC_DE 0
// ****************************************************
// Operation register fields and reset values
// ****************************************************
`define TCD_OP_PR 3
`define TCD_OP_AE 2
`define TCD_OP_NMI 1
`define TCD_OP_DME 0
`define TCD_CC_RESET 16'h0000
`define TCD_OP_RESET 4'h0
`define TCD_RS_RESET 2'h0
`endif

// *** test/tcd_dma_control_sva.sv ***
`include "tcd_defines.vh"

module tcd_dma_control_sva (
    input wire clk,
    input wire resetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [1:0] request_ack_pin,
    input wire [1:0] end_irq,
    input wire bus_hold,
    input wire bus_read,
    input wire bus_write
);
    // ****************************************************
    // Shadows of software writes
    // ****************************************************
    localparam [31:0] I_C0 = `TCD_IDX_CHC0;
    localparam [31:0] I_C1 = `TCD_IDX_CHC1;
    localparam [31:0] I_OP = `TCD_IDX_OPER;
    reg wph_reg; // Write data phase in progress
    reg [29:0] wa_reg; // Word address of that write
    reg [15:0] cc0_reg;
    reg [15:0] cc1_reg;
    reg dme_reg;
    // Track only software-owned bits; hardware flags are not mirrored
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wph_reg <= 1'b0;
            wa_reg <= 30'h0;
            cc0_reg <= 16'h0000;
            cc1_reg <= 16'h0000;
            dme_reg <= 1'b0;
        end else begin
            wph_reg <= hsel && htrans[1] && hready && hwrite;
            wa_reg <= haddr[31:2];
            if (wph_reg && wa_reg == I_C0[29:0]) cc0_reg <= hwdata[15:0];
            if (wph_reg && wa_reg == I_C1[29:0]) cc1_reg <= hwdata[15:0];
            if (wph_reg && wa_reg == I_OP[29:0]) dme_reg <= hwdata[0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    rw_excl_a: assert property (bus_read |-> bus_hold && !bus_write)
        else $error("read cycle outside busy or beside write");
    ack_idle_a: assert property (!bus_hold |->
        request_ack_pin[0] == !cc0_reg[7]) else $error("ack level when idle");
    ack_cycle_a: assert property ((request_ack_pin[0] == cc0_reg[7]
        && !cc0_reg[3]) |-> (cc0_reg[8] ? bus_write : bus_read))
        else $error("ack in wrong cycle");
    irq_gate_a: assert property (end_irq[0] |-> cc0_reg[2])
        else $error("irq 0 without gate");
    irq_gate_one_a: assert property (end_irq[1] |-> cc1_reg[2])
        else $error("irq 1 without gate");
    irq_rise_a: assert property ($rose(end_irq[0]) |->
        $past(bus_write) || $past(wph_reg)) else $error("irq rose alone");
    irq_fall_a: assert property ($fell(end_irq[0]) |-> $past(wph_reg))
        else $error("irq fell without write");
    gate_off_a: assert property (!dme_reg [*3] |-> !bus_hold)
        else $error("busy while global gate off");
    chan_off_a: assert property ((!cc0_reg[0] && !cc1_reg[0]) [*3]
        |-> !bus_hold) else $error("busy while channels off");
    cover property (bus_read ##1 bus_write);
    cover property ($rose(end_irq[0]));
    cover property (bus_hold && request_ack_pin[0] && cc0_reg[7]);
endmodule // tcd_dma_control_sva

bind tcd_dma_control tcd_dma_control_sva u_sva (.clk(clk), .resetn(resetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .request_ack_pin(request_ack_pin),
    .end_irq(end_irq), .bus_hold(bus_hold), .bus_read(bus_read),
    .bus_write(bus_write));

// *** test/tcd_periph_model.sv ***
module tcd_periph_model (
    input wire clk,
    input wire resetn,
    input wire go,
    input wire act_high,
    input wire ack_high,
    input wire ack,
    output wire req,
    output reg pend,
    output integer acks
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************
    // Peripheral holding a request until acknowledged
    // ****************************************************
    reg seen_reg; // Ack was active last cycle
    // Idle at inactive level, so going active is also the edge
    assign req = pend ? act_high : !act_high;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pend <= 1'b0;
            seen_reg <= 1'b0;
            acks <= 0;
        end else begin
            seen_reg <= (ack == ack_high);
            if (go) pend <= 1'b1;
            else if (ack == ack_high) pend <= 1'b0;
            // One count per unit: ack rises once each
            if (ack == ack_high && !seen_reg) acks <= acks + 1;
        end
    end
endmodule // tcd_periph_model

// *** test/tcd_dma_control_tb_top.sv ***
`include "tcd_defines.vh"

module tcd_dma_control_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************
    // Bench signals and byte addresses
    // ****************************************************
    localparam [31:0] A_OP = `TCD_IDX_OPER << 2;
    localparam [31:0] A_RS0 = `TCD_IDX_RSEL0 << 2;
    localparam [31:0] A_CC0 = `TCD_IDX_CHC0 << 2;
    localparam [31:0] A_CN0 = `TCD_IDX_CNT0 << 2;
    localparam [31:0] A_SR0 = `TCD_IDX_SRC0 << 2;
    localparam [31:0] A_DS0 = `TCD_IDX_DST0 << 2;
    reg clk = 0, resetn = 0, hsel = 0, hwrite = 0, nmi = 0, go = 0, ahi = 0;
    reg [31:0] haddr = 0, hwdata = 0, d;
    reg [1:0] htrans = 0, srx = 0, stx = 0;
    wire hrdy, bhold, brd, bwr, req, pend;
    wire [31:0] hrdata, baddr;
    wire [1:0] ack, irq;
    integer err_total = 0, n_compared = 0, acks, nrd = 0, a0, i, j, k;
    always #12.5 clk = !clk;
    // Count source reads of the engine
    always @(posedge clk) if (brd === 1'b1) nrd = nrd + 1;
    tcd_dma_control uut (.clk(clk), .resetn(resetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(),
        .hrdata(hrdata), .external_request_pin({1'b1, req}),
        .serial_receive_request(srx), .serial_transmit_request(stx),
        .nmi_event(nmi), .request_ack_pin(ack), .end_irq(irq),
        .bus_hold(bhold), .bus_addr(baddr), .bus_read(brd), .bus_write(bwr),
        .bus_size());
    tcd_periph_model pm (.clk(clk), .resetn(resetn), .go(go),
        .act_high(ahi), .ack_high(1'b1), .ack(ack[0]), .req(req),
        .pend(pend), .acks(acks));
    task chk(input [31:0] seen, input [31:0] exp, input string nm);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Bus cycles hold the request until hready is sampled high
    task wr(input [31:0] a, input [31:0] v);
        hsel <= 1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= 1;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        hsel <= 0;
        htrans <= 0;
        hwdata <= v;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
    endtask
    task rd(input [31:0] a);
        hsel <= 1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= 0;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        hsel <= 0;
        htrans <= 0;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        d = hrdata;
    endtask
    task clr(input integer ch);
        rd(A_CC0 + 4 * ch);
        wr(A_CC0 + 4 * ch, 0);
    endtask
    task wait_irq(input integer ch);
        for (k = 0; k < 300 && irq[ch] !== 1'b1; k = k + 1) @(posedge clk);
        chk(irq[ch], 1, "end_irq");
    endtask
    task t_reset;
        for (i = 0; i < 4; i = i + 1) begin
            rd(i == 0 ? A_OP : i == 1 ? A_CC0 : i == 2 ? A_RS0 : 32'h0ff0);
            chk(d, 0, "reset value");
        end
        chk(ack, 2'h3, "ack idle");
    endtask
    // Round robin first, then fixed; both channels armed together
    task t_prio;
        for (i = 0; i < 2; i = i + 1) begin
            wr(A_OP, 0);
            for (j = 0; j < 2; j = j + 1) begin
                wr(A_SR0 + 4 * j, 32'h100 + j);
                wr(A_DS0 + 4 * j, 32'h200 + j);
                wr(A_CN0 + 4 * j, 1);
                wr(A_CC0 + 4 * j, 32'h205);
            end
            repeat (10) @(posedge clk);
            chk(bhold, 0, "bus_hold");
            wr(A_OP, i == 0 ? 32'h9 : 32'h1);
            for (k = 0; k < 50 && brd !== 1'b1; k = k + 1) @(posedge clk);
            chk(baddr, i == 0 ? 32'h101 : 32'h100, "first");
            @(posedge clk);
            chk(baddr, i == 0 ? 32'h201 : 32'h200, "dest");
            wait_irq(0);
            wait_irq(1);
            clr(0);
            clr(1);
        end
    endtask
    // Byte units, then one sixteen-byte unit
    task t_units;
        for (i = 0; i < 2; i = i + 1) begin
            nrd = 0;
            wr(A_SR0, 32'h400);
            wr(A_CN0, 2 - i);
            wr(A_CC0, i ? 32'h1e15 : 32'h1215);
            wait_irq(0);
            rd(A_CN0);
            chk(d, 0, "count");
            rd(A_SR0);
            chk(d, i ? 32'h410 : 32'h402, "source");
            chk(nrd, i ? 4 : 2, "reads");
            wr(A_CC0, 32'h4);
            @(posedge clk);
            chk(irq[0], 1, "irq kept");
            rd(A_CC0);
            chk(d, 32'h6, "end flag");
            wr(A_CC0, 32'h4);
            @(posedge clk);
            chk(irq[0], 0, "irq cleared");
        end
    endtask
    task t_err;
        nrd = 0;
        wr(A_SR0, 32'h401);
        wr(A_CN0, 1);
        wr(A_CC0, 32'h0a01);
        repeat (10) @(posedge clk);
        chk(nrd, 0, "no reads");
        rd(A_OP);
        chk(d, 32'h5, "addr error");
        wr(A_CC0, 0);
        nmi <= 1;
        @(posedge clk);
        nmi <= 0;
        rd(A_OP);
        chk(d, 32'h7, "nmi flag");
        wr(A_OP, 32'h7);
        rd(A_OP);
        chk(d, 32'h7, "flags kept");
        wr(A_OP, 32'h1);
        rd(A_OP);
        chk(d, 32'h1, "flags cleared");
    endtask
    // Pin by rising edge, pin by low level, serial receive, transmit
    task t_src;
        for (i = 0; i < 4; i = i + 1) begin
            wr(A_RS0, i < 2 ? 0 : i - 1);
            ahi <= (i == 0);
            wr(A_CN0, 2);
            wr(A_CC0, i == 0 ? 32'h1ed : 32'h18d);
            srx <= {1'b0, i == 2};
            stx <= {1'b0, i == 3};
            a0 = acks;
            for (j = 0; j < 2; j = j + 1) begin
                go <= 1;
                @(posedge clk);
                go <= 0;
                repeat (20) @(posedge clk);
            end
            wait_irq(0);
            chk(acks - a0, 2, "acks");
            srx <= 0;
            stx <= 0;
            clr(0);
        end
    endtask
    task report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        err_total = err_total + 1;
        report_and_stop;
    end
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1;
        @(posedge clk);
        t_reset;
        t_prio;
        t_units;
        t_err;
        t_src;
        report_and_stop;
    end
endmodule // tcd_dma_control_tb_top
